/* File: gpc_pkg.sv */
// Purpose: shared constants for the four-pin port with ganged drive
// Assumes: APB byte addressing of word registers, 32-bit data, four port pins
// Notes: reset values clear every setting so all pins float as inputs

// ============================================================
// package
package gpc_pkg;
    // number of port pins
    localparam int GPC_NPINS = 4;
    // register byte offsets
    localparam logic [7:0] GPC_OFF_DATA = 8'h00;
    localparam logic [7:0] GPC_OFF_DIR = 8'h04;
    localparam logic [7:0] GPC_OFF_PULL = 8'h08;
    localparam logic [7:0] GPC_OFF_SLEW = 8'h0c;
    localparam logic [7:0] GPC_OFF_DRIVE = 8'h10;
    localparam logic [7:0] GPC_OFF_GANG = 8'h14;
    // gang control field positions
    localparam int GPC_GANG_EN_BIT = 0;
    localparam int GPC_GANG_SEL_LO = 1;
    localparam int GPC_GANG_SEL_HI = 7;
    // reset values
    localparam logic [3:0] GPC_RST_PORT = 4'h0;
    localparam logic [7:0] GPC_RST_GANG = 8'h00;

    // direction after the gang enable forces pin zero to output
    function automatic logic [3:0] gpc_eff_dir(input logic [3:0] dir,
                                               input logic gang_en);
        gpc_eff_dir = dir | {3'h0, gang_en};
    endfunction
endpackage

/* File: gpc_cfg_if.sv */
// Purpose: carries port settings from the register block to the pad stage
// Assumes: single pclk domain
// Notes: gang_mask bit 0 is always low, pin zero is the gang source

`timescale 1ns/1ns

// ============================================================
// settings carrier
interface gpc_cfg_if;
    logic [3:0] data;      // latched data
    logic [3:0] dir;       // direction bits
    logic [3:0] pull;      // pull enable bits
    logic [3:0] slew;      // slew enable bits
    logic [3:0] drive;     // drive select bits
    logic gang_en;         // gang enable
    logic [3:0] gang_mask; // ganged pins of this port

    // register side
    modport regs (output data, dir, pull, slew, drive, gang_en, gang_mask);
    // pad side
    modport pads (input data, dir, pull, slew, drive, gang_en, gang_mask);
endinterface

/* File: gpc_pad_ctrl.sv */
// Purpose: turns port settings into registered pad controls
// Assumes: settings come from the register block through gpc_cfg_if
// Notes: pad controls follow the settings one clock later

`timescale 1ns/1ns

// ============================================================
// pad control stage
module gpc_pad_ctrl
    import gpc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // settings
    gpc_cfg_if.pads cfg,
    // pad controls
    output logic [3:0] pad_o,
    output logic [3:0] pad_oe,
    output logic [3:0] pad_pull,
    output logic [3:0] pad_slew,
    output logic [3:0] pad_drive
);
    logic [3:0] o_d, oe_d, pull_d, slew_d, drive_d;
    logic [3:0] o_q, oe_q, pull_q, slew_q, drive_q;
    logic [3:0] edir; // effective direction
    logic [3:0] gsel; // pins slaved to pin zero

    // next pad state
    always_comb begin
        edir = gpc_eff_dir(cfg.dir, cfg.gang_en);
        gsel = cfg.gang_mask & {4{cfg.gang_en}};
        for (int i = 0; i < 4; i++) begin
            o_d[i] = gsel[i] ? cfg.data[0] : cfg.data[i];
            slew_d[i] = (gsel[i] ? cfg.slew[0] : cfg.slew[i]) & edir[i];
            drive_d[i] = (gsel[i] ? cfg.drive[0] : cfg.drive[i]) & edir[i];
            pull_d[i] = cfg.pull[i] & ~edir[i];
        end
        oe_d = edir;
    end

    // pad state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            o_q <= 4'h0;
            oe_q <= 4'h0;
            pull_q <= 4'h0;
            slew_q <= 4'h0;
            drive_q <= 4'h0;
        end else begin
            o_q <= o_d;
            oe_q <= oe_d;
            pull_q <= pull_d;
            slew_q <= slew_d;
            drive_q <= drive_d;
        end
    end

    assign pad_o = o_q;
    assign pad_oe = oe_q;
    assign pad_pull = pull_q;
    assign pad_slew = slew_q;
    assign pad_drive = drive_q;
endmodule

/* File: gpc_port.sv */
// Purpose: four-pin port registers with write-once ganged drive
// Assumes: APB slave on pclk, pins synchronous to pclk
// Notes: zero wait states, unmapped offsets answer with pslverr
//
// How it works
// - direction bit set enables pin driver
// - data read: input pins live, outputs latched
// - pull bit connects pull-up to pin
// - outputs always have pull-up disconnected
// - slew bit controls output slew only
// - drive bit set selects high drive
// - gang pin selects in bits seven to one
// - ganged pins copy pin zero data, slew and drive
// - selects act only with gang enable
// - gang control bit zero enables ganging
// - gang enable forces pin zero output
// - data writes latched, driven on outputs
// - reset clears data, pins float undriven
//
// The register addresses and the APB register port were decided locally.

`timescale 1ns/1ns

// ============================================================
// port top
module gpc_port
    import gpc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic [3:0] pin_i,
    output logic [3:0] pin_o,
    output logic [3:0] pin_oe,
    // pad controls
    output logic [3:0] pull_en,
    output logic [3:0] slew_en,
    output logic [3:0] drive_hi
);
    // ========================================================
    // state
    logic [3:0] port_data_latch_q, port_data_latch_d;
    logic [3:0] pin_direction_bits_q, pin_direction_bits_d;
    logic [3:0] pull_enable_bits_q, pull_enable_bits_d;
    logic [3:0] slew_enable_bits_q, slew_enable_bits_d;
    logic [3:0] drive_select_bits_q, drive_select_bits_d;
    logic [7:0] gang_control_q, gang_control_d;
    logic gang_written_q, gang_written_d; // first write seen
    logic [31:0] rdata_q, rdata_d;        // read data
    logic err_q, err_d;                   // unmapped offset

    // bus decode helpers
    logic setup;      // setup cycle
    logic wr_acc;     // write takes effect
    logic mapped;     // offset hits a register
    logic [3:0] edir; // effective direction
    logic [3:0] data_view; // data read-back

    // gang fields
    logic gang_enable;
    logic [7:1] gang_pin_select;

    // ========================================================
    // bus decode
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & ~err_q;
    assign pready = 1'b1;
    assign gang_enable = gang_control_q[GPC_GANG_EN_BIT];
    assign gang_pin_select = gang_control_q[GPC_GANG_SEL_HI:GPC_GANG_SEL_LO];
    assign edir = gpc_eff_dir(pin_direction_bits_q, gang_enable);

    assign data_view = (pin_i & ~edir) | (port_data_latch_q & edir);

    // offset check
    always_comb begin
        if (paddr == GPC_OFF_DATA) begin
            mapped = 1'b1;
        end else if (paddr == GPC_OFF_DIR) begin
            mapped = 1'b1;
        end else if (paddr == GPC_OFF_PULL) begin
            mapped = 1'b1;
        end else if (paddr == GPC_OFF_SLEW) begin
            mapped = 1'b1;
        end else if (paddr == GPC_OFF_DRIVE) begin
            mapped = 1'b1;
        end else if (paddr == GPC_OFF_GANG) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // ========================================================
    // read data and error, captured in the setup cycle
    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup) begin
            err_d = ~mapped;
            if (paddr == GPC_OFF_DATA) begin
                rdata_d = {28'h0, data_view};
            end else if (paddr == GPC_OFF_DIR) begin
                rdata_d = {28'h0, pin_direction_bits_q};
            end else if (paddr == GPC_OFF_PULL) begin
                rdata_d = {28'h0, pull_enable_bits_q};
            end else if (paddr == GPC_OFF_SLEW) begin
                rdata_d = {28'h0, slew_enable_bits_q};
            end else if (paddr == GPC_OFF_DRIVE) begin
                rdata_d = {28'h0, drive_select_bits_q};
            end else if (paddr == GPC_OFF_GANG) begin
                rdata_d = {24'h0, gang_control_q};
            end else begin
                rdata_d = 32'h0;
            end
        end
    end

    // read path registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // error only shows in the access phase
    assign prdata = rdata_q;
    assign pslverr = psel & penable & err_q;

    // ========================================================
    // register writes
    always_comb begin
        port_data_latch_d = port_data_latch_q;
        pin_direction_bits_d = pin_direction_bits_q;
        pull_enable_bits_d = pull_enable_bits_q;
        slew_enable_bits_d = slew_enable_bits_q;
        drive_select_bits_d = drive_select_bits_q;
        gang_control_d = gang_control_q;
        gang_written_d = gang_written_q;
        if (wr_acc) begin
            if (paddr == GPC_OFF_DATA) begin
                port_data_latch_d = pwdata[3:0];
            end else if (paddr == GPC_OFF_DIR) begin
                pin_direction_bits_d = pwdata[3:0];
            end else if (paddr == GPC_OFF_PULL) begin
                pull_enable_bits_d = pwdata[3:0];
            end else if (paddr == GPC_OFF_SLEW) begin
                slew_enable_bits_d = pwdata[3:0];
            end else if (paddr == GPC_OFF_DRIVE) begin
                drive_select_bits_d = pwdata[3:0];
            end else if (paddr == GPC_OFF_GANG) begin
                if (!gang_written_q) begin
                    gang_control_d = pwdata[7:0];
                    gang_written_d = 1'b1;
                end
            end
        end
    end

    // register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_latch_q <= GPC_RST_PORT;
            pin_direction_bits_q <= GPC_RST_PORT;
            pull_enable_bits_q <= GPC_RST_PORT;
            slew_enable_bits_q <= GPC_RST_PORT;
            drive_select_bits_q <= GPC_RST_PORT;
            gang_control_q <= GPC_RST_GANG;
            gang_written_q <= 1'b0;
        end else begin
            port_data_latch_q <= port_data_latch_d;
            pin_direction_bits_q <= pin_direction_bits_d;
            pull_enable_bits_q <= pull_enable_bits_d;
            slew_enable_bits_q <= slew_enable_bits_d;
            drive_select_bits_q <= drive_select_bits_d;
            gang_control_q <= gang_control_d;
            gang_written_q <= gang_written_d;
        end
    end

    // ========================================================
    // pad stage
    gpc_cfg_if cfg ();

    assign cfg.data = port_data_latch_q;
    assign cfg.dir = pin_direction_bits_q;
    assign cfg.pull = pull_enable_bits_q;
    assign cfg.slew = slew_enable_bits_q;
    assign cfg.drive = drive_select_bits_q;
    assign cfg.gang_en = gang_enable;
    // selects of pins one to three
    assign cfg.gang_mask = {gang_pin_select[3:1], 1'b0};

    gpc_pad_ctrl u_pads (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg),
        .pad_o(pin_o),
        .pad_oe(pin_oe),
        .pad_pull(pull_en),
        .pad_slew(slew_en),
        .pad_drive(drive_hi)
    );

    // ========================================================
    // checks
    logic rd_data_acc; // read of data offset in access phase
    assign rd_data_acc = psel & penable & ~pwrite & (paddr == GPC_OFF_DATA);

    a_dir_to_oe: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 pin_oe[3:1] == $past(pin_direction_bits_q[3:1]))
        else $error("pin driver does not follow direction");

    a_read_view: assert property (@(posedge pclk) disable iff (!presetn)
        rd_data_acc |-> prdata[3:0] == $past(data_view))
        else $error("data read-back wrong");

    a_pull_input: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 pull_en == $past(pull_enable_bits_q & ~edir))
        else $error("pull-up does not follow pull bit");

    a_pull_off_out: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_oe & pull_en) == 4'h0)
        else $error("pull-up active on output");

    // slew and drive gated by input
    a_input_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        ((slew_en | drive_hi) & ~pin_oe) == 4'h0)
        else $error("slew or drive active on input");

    a_drive_src: assert property (@(posedge pclk) disable iff (!presetn)
        (!gang_enable && pin_direction_bits_q[2]) ##1 1'b1
        |-> drive_hi[2] == $past(drive_select_bits_q[2]))
        else $error("drive select not applied");

    a_gang_copy: assert property (@(posedge pclk) disable iff (!presetn)
        (gang_enable && gang_pin_select[1])
        |=> pin_o[1] == pin_o[0])
        else $error("ganged pin differs from pin zero");

    a_gang_off: assert property (@(posedge pclk) disable iff (!presetn)
        !gang_enable |=> pin_o == $past(port_data_latch_q))
        else $error("pin data not its own without gang");

    a_pin0_forced: assert property (@(posedge pclk) disable iff (!presetn)
        gang_enable |=> pin_oe[0])
        else $error("pin zero not driven while ganged");

    a_data_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == GPC_OFF_DATA)
        |=> port_data_latch_q == $past(pwdata[3:0]))
        else $error("data write not latched");

    a_idle_float: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_direction_bits_q == 4'h0 && !gang_enable)
        |=> pin_oe == 4'h0)
        else $error("pin driven while all inputs");

    a_once_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (gang_written_q && wr_acc && paddr == GPC_OFF_GANG)
        |=> $stable(gang_control_q))
        else $error("gang control changed after first write");

    // scenarios
    c_gang_on: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(gang_enable));
    c_read_input: cover property (@(posedge pclk) disable iff (!presetn)
        rd_data_acc && edir != 4'hf);
    c_second_gang: cover property (@(posedge pclk) disable iff (!presetn)
        gang_written_q && wr_acc && paddr == GPC_OFF_GANG);
endmodule

/* File: gpc_pad_model.sv */
// Purpose: board and pad model around the four port pins
// Assumes: one pclk domain, board drivers set by the bench
// Notes: an undriven pin with no pull-up shows a toggling level

`timescale 1ns/1ns

// ============================================================
// pad model
module gpc_pad_model (
    // clock
    input wire logic pclk,
    // port side
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pull_en,
    // board side
    input wire logic [3:0] ext_oe,
    input wire logic [3:0] ext_val,
    // level seen by the port
    output logic [3:0] pin_i
);
    logic [3:0] float_q = 4'h5; // level of a floating pin

    // floating pins change every cycle so no stale value survives
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i]) begin
                pin_i[i] = pin_o[i];
            end else if (ext_oe[i]) begin
                pin_i[i] = ext_val[i];
            end else if (pull_en[i]) begin
                pin_i[i] = 1'b1;
            end else begin
                pin_i[i] = float_q[i];
            end
        end
    end
endmodule

/* File: four_bit_port_with_ganged_drive_test.sv */
// Purpose: self-checking bench for the four-pin port with ganged drive
// Assumes: zero-wait apb slave, pad outputs one clock after settings
// Notes: random settings from a fixed seed, corner cases by hand

`timescale 1ns/1ns

// ============================================================
// bench top
module four_bit_port_with_ganged_drive_test import gpc_pkg::*; ();
    // clock, reset and apb
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    // pins and pad controls
    logic [3:0] pin_i, pin_o, pin_oe, pull_en, slew_en, drive_hi;
    logic [3:0] ext_oe, ext_val; // board drivers
    // bench state
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [3:0] m_data, m_dir, m_pull, m_slew, m_drive; // register model
    logic [7:0] m_gang;
    logic m_lock;
    logic [31:0] rd;
    logic er;

    gpc_port gpc_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull_en),
        .slew_en(slew_en), .drive_hi(drive_hi));
    gpc_pad_model gpc_pad_model_inst (.pclk(pclk), .pin_o(pin_o),
        .pin_oe(pin_oe), .pull_en(pull_en), .ext_oe(ext_oe),
        .ext_val(ext_val), .pin_i(pin_i));

    // ============================================================
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end

    // ============================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one apb transfer, entered and left just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // write and update the register model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a)
            GPC_OFF_DATA: m_data = d[3:0];
            GPC_OFF_DIR: m_dir = d[3:0];
            GPC_OFF_PULL: m_pull = d[3:0];
            GPC_OFF_SLEW: m_slew = d[3:0];
            GPC_OFF_DRIVE: m_drive = d[3:0];
            GPC_OFF_GANG: begin
                if (!m_lock) m_gang = d[7:0];
                m_lock = 1'b1;
            end
            default: ;
        endcase
    endtask

    // expected {data, oe, pull, slew, drive} at the pads
    function automatic logic [19:0] exp_pads();
        logic [3:0] ed, mk, o, sl, dr;
        ed = m_dir | {3'h0, m_gang[0]};
        mk = m_gang[0] ? {m_gang[3:1], 1'b0} : 4'h0;
        for (int i = 0; i < 4; i++) begin
            o[i] = mk[i] ? m_data[0] : m_data[i];
            sl[i] = ed[i] & (mk[i] ? m_slew[0] : m_slew[i]);
            dr[i] = ed[i] & (mk[i] ? m_drive[0] : m_drive[i]);
        end
        return {o & ed, ed, m_pull & ~ed, sl, dr};
    endfunction

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("pads in reset", {12'h0, pin_o, pin_oe, pull_en, slew_en,
            drive_hi}, 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        {m_data, m_dir, m_pull, m_slew, m_drive, m_gang, m_lock} = '0;
        @(posedge pclk);
    endtask

    // random settings, then pads and read-back compared
    task automatic step();
        logic [3:0] ed;
        logic [31:0] mk, ev;
        ext_oe <= 4'($urandom);
        ext_val <= 4'($urandom);
        wr(GPC_OFF_DATA, $urandom);
        wr(GPC_OFF_DIR, $urandom);
        wr(GPC_OFF_PULL, $urandom);
        wr(GPC_OFF_SLEW, $urandom);
        wr(GPC_OFF_DRIVE, $urandom);
        @(negedge pclk);
        chk("pads", {12'h0, pin_o & pin_oe, pin_oe, pull_en, slew_en,
            drive_hi}, {12'h0, exp_pads()});
        ed = m_dir | {3'h0, m_gang[0]};
        mk = {28'h0, ed | ext_oe | m_pull};
        ev = {28'h0, (ed & m_data) | (~ed & (ext_val | ~ext_oe))};
        @(posedge pclk);
        apb(1'b0, GPC_OFF_DATA, 32'h0);
        chk("data read", rd & mk, ev & mk);
        apb(1'b0, GPC_OFF_DIR, 32'h0);
        chk("dir read", rd, {28'h0, m_dir});
        chk("mapped err", {31'h0, er}, 32'h0);
    endtask

    // ============================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_oe, ext_val} = '0;
        rd = $urandom(77);
        @(posedge pclk);
        do_reset();
        for (int i = 1; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        $display("test reset done");
        repeat (15) step();
        $display("test plain port done");
        apb(1'b1, 8'h18, 32'hffffffff);
        chk("unmapped write err", {31'h0, er}, 32'h1);
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped read", rd, 32'h0);
        chk("unmapped read err", {31'h0, er}, 32'h1);
        $display("test unmapped done");
        wr(GPC_OFF_GANG, {24'h0, 8'($urandom) | 8'h0b});
        wr(GPC_OFF_GANG, 32'h0);
        apb(1'b0, GPC_OFF_GANG, 32'h0);
        chk("gang locked", rd, {24'h0, m_gang});
        repeat (15) step();
        $display("test ganged done");
        do_reset();
        apb(1'b0, GPC_OFF_GANG, 32'h0);
        chk("gang after reset", rd, 32'h0);
        wr(GPC_OFF_GANG, {24'h0, 8'($urandom) & 8'hfe});
        wr(GPC_OFF_GANG, 32'h1);
        apb(1'b0, GPC_OFF_GANG, 32'h0);
        chk("selects only", rd, {24'h0, m_gang});
        repeat (10) step();
        $display("test selects without enable done");
        end_sim();
    end
endmodule
